/* File: logic/tsv_pkg.sv */
// Package for the timeout supervisor: field widths, encodings, reset values.
// Assumes a single 40 MHz clock domain; no other package is needed.
package tsv_pkg;
    localparam int unsigned CNT_W       = 32;           // Counter width
    localparam int unsigned RANGE_W     = 4;            // Timeout range select width
    localparam int unsigned RANGE_N     = 16;           // Number of defined ranges
    localparam int unsigned PLEN_W      = 8;            // Reset pulse length width
    localparam int unsigned RANGE_BASE  = 16;           // Range k gives 2^(RANGE_BASE+k)-1, top is full
    localparam logic [31:0] CNT_RST     = 32'hFFFFFFFF; // Counter value after reset
    localparam logic [3:0]  RANGE_RST   = 4'hF;         // Longest range after reset
    // Response modes
    typedef enum logic [0:0]
    {
        TSV_MODE_RESET = 1'b0,
        TSV_MODE_IRQ   = 1'b1
    } tsv_mode_e;
    // Reset pulse states
    typedef enum logic [0:0]
    {
        TSV_ST_IDLE  = 1'b0,
        TSV_ST_PULSE = 1'b1
    } tsv_state_e;
endpackage

/* File: logic/tsv_range_lut.sv */
// Preset lookup: turns the 4-bit range select into a 32-bit preset.
// Assumes it is combinational, fed from the same clock domain.
`timescale 1ns/1ps
module tsv_range_lut
#(
    parameter int unsigned RANGE_BASE = tsv_pkg::RANGE_BASE
)
(
    input  wire logic [3:0]  range_sel,
    output wire logic [31:0] preset
);
    // Sixteen ranges, each a power of two less one; the top range is the full
    // counter span, so software can always reach the longest possible period
    logic [31:0] table_w [tsv_pkg::RANGE_N];
    genvar k;
    generate
        for (k = 0; k < tsv_pkg::RANGE_N; k++)
        begin : g_rng
            assign table_w[k] = (k == tsv_pkg::RANGE_N - 1) ? tsv_pkg::CNT_RST
                              : 32'((64'h1 << (RANGE_BASE + k)) - 64'h1);
        end
    endgenerate
    assign preset = table_w[range_sel];
endmodule

/* File: logic/tsv_timeout_supervisor.sv */
// Timeout supervisor: 32-bit down-counting watchdog with reset or interrupt-first response.
// Assumes control bits arrive from logic on clk (no bus), outputs go to an
// interrupt controller and a system reset generator.
// Range k loads 2^(RANGE_BASE+k)-1; range 15 loads the full 32-bit span.
// The reset pulse lasts pulse_len+1 cycles; a new timeout restarts it.
// After any timeout the counter reloads itself and keeps running.
// The interrupt stays set until cleared, even after the reset fires.
//
// Contract
// (RULE_01) Counter and preset are thirty-two bits wide
// (RULE_02) Counter steps on the bus clock only
// (RULE_03) Load preset, count down, zero means timeout
// (RULE_04) Direct mode: timeout asserts system reset immediately
// (RULE_05) Interrupt mode: uncleared interrupt, second timeout resets
// (RULE_06) Reset pulse length set by software
// (RULE_07) Sixteen timeout ranges via four-bit select
// (RULE_08) Clearing or restarting reloads the preset
`timescale 1ns/1ps
module tsv_timeout_supervisor
#(
    parameter int unsigned PLEN_W     = tsv_pkg::PLEN_W,
    parameter int unsigned RANGE_BASE = tsv_pkg::RANGE_BASE
)
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              enable,
    input  wire logic              mode_irq,
    input  wire logic [3:0]        range_sel,
    input  wire logic [PLEN_W-1:0] pulse_len,
    input  wire logic              restart,
    input  wire logic              irq_clear,
    output logic                   irq,
    output logic                   sys_reset,
    output logic [31:0]            count
);
    initial
    begin
        if (PLEN_W < 1 || PLEN_W > 16)
            $error("PLEN_W must be 1..16");
        // Range 14 must still fit in 32 bits below the full-span top range
        if (RANGE_BASE < 1 || RANGE_BASE > 17)
            $error("RANGE_BASE must be 1..17");
    end

    logic [31:0]       cnt_r;
    logic [31:0]       cnt_nxt;
    logic              irq_r;
    logic              irq_nxt;
    logic [PLEN_W-1:0] plen_r;
    logic [PLEN_W-1:0] plen_nxt;
    tsv_pkg::tsv_state_e st_r;
    tsv_pkg::tsv_state_e st_nxt;
    logic [31:0]       preset;

    // Preset lookup from the range select [RULE_07]
    tsv_range_lut
    #(
        .RANGE_BASE (RANGE_BASE)
    )
    u_lut
    (
        .range_sel (range_sel),
        .preset    (preset)
    );

    // Event decode
    wire logic service  = restart | irq_clear;
    wire logic timeout  = enable && (cnt_r == 32'h00000000);               // [RULE_03]
    wire logic fire_rst = timeout && (!mode_irq || irq_r);                 // [RULE_04] [RULE_05]
    wire logic fire_irq = timeout && mode_irq && !irq_r;                   // [RULE_05]
    wire logic pulsing  = (st_r == tsv_pkg::TSV_ST_PULSE);

    // Counter: reload while stopped, on service or after timeout, else step down per clk [RULE_02]
    // A timeout in the same cycle as a service still counts, so it is not lost
    assign cnt_nxt = (!enable || service || timeout) ? preset               // [RULE_08]
                   : 32'(cnt_r - 32'h00000001);                            // [RULE_01] [RULE_03]

    // Interrupt flag: the set wins over a clear in the same cycle
    assign irq_nxt = fire_irq ? 1'b1 : (irq_clear ? 1'b0 : irq_r);          // [RULE_05]

    // Reset pulse counter; a length of zero still gives one cycle
    assign plen_nxt = fire_rst ? pulse_len                                  // [RULE_06]
                    : (plen_r != '0) ? PLEN_W'(plen_r - 1'b1) : plen_r;

    // Reset pulse state; a timeout during a pulse restarts its length [RULE_06]
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            tsv_pkg::TSV_ST_IDLE:
            begin
                if (fire_rst)
                    st_nxt = tsv_pkg::TSV_ST_PULSE;
            end
            tsv_pkg::TSV_ST_PULSE:
            begin
                if (!fire_rst && plen_r == '0)
                    st_nxt = tsv_pkg::TSV_ST_IDLE;
            end
            default:
            begin
                st_nxt = tsv_pkg::TSV_ST_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_r  <= tsv_pkg::CNT_RST;
            irq_r  <= 1'b0;
            plen_r <= '0;
            st_r   <= tsv_pkg::TSV_ST_IDLE;
        end
        else
        begin
            cnt_r  <= cnt_nxt;
            irq_r  <= irq_nxt;
            plen_r <= plen_nxt;
            st_r   <= st_nxt;
        end
    end

    // Outputs all from flip-flops; reset output comes one clock after timeout
    assign irq       = irq_r;
    assign sys_reset = pulsing;
    assign count     = cnt_r;

    // Helper: cycles the reset pulse has stood, so a stuck pulse is caught
    logic [PLEN_W:0] hold_r;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            hold_r <= '0;
        else
            hold_r <= (fire_rst || !pulsing) ? '0 : (PLEN_W+1)'(hold_r + 1'b1);
    end

    // Checks
    // Direct mode: reset follows the timeout one clock later
    a_direct_reset: assert property (@(posedge clk) disable iff (rst) // [RULE_04]
        (enable && cnt_r == 0 && !mode_irq) |=> sys_reset)
        else $error("direct timeout did not assert reset");

    // Interrupt mode: first timeout only interrupts
    a_irq_first: assert property (@(posedge clk) disable iff (rst) // [RULE_05]
        (enable && cnt_r == 0 && mode_irq && !irq_r && !sys_reset) |=> (irq && !sys_reset))
        else $error("first timeout did not raise interrupt only");

    // Interrupt mode: a timeout with the interrupt still set resets
    a_second_timeout: assert property (@(posedge clk) disable iff (rst) // [RULE_05]
        (enable && cnt_r == 0 && mode_irq && irq_r) |=> sys_reset)
        else $error("second timeout did not reset");

    // Plain counting: one step down per clock
    a_count_down: assert property (@(posedge clk) disable iff (rst) // [RULE_03]
        (enable && !restart && !irq_clear && cnt_r != 0) |=> cnt_r == $past(cnt_r) - 1)
        else $error("counter did not decrement");

    // Restart on the top range loads the full span
    a_service_load: assert property (@(posedge clk) disable iff (rst) // [RULE_08]
        (restart && range_sel == 4'hF) |=> cnt_r == 32'hFFFFFFFF)
        else $error("service did not reload preset");

    // Shortest range preset after any service
    a_range_min: assert property (@(posedge clk) disable iff (rst) // [RULE_07]
        (service && range_sel == 4'h0) |=> cnt_r == 32'((64'h1 << RANGE_BASE) - 64'h1))
        else $error("range zero preset wrong");

    // Second range is twice as long as the first
    a_range_step: assert property (@(posedge clk) disable iff (rst) // [RULE_07]
        (service && range_sel == 4'h1) |=> cnt_r == 32'((64'h1 << (RANGE_BASE + 1)) - 64'h1))
        else $error("range one preset wrong");

    // A length of two gives three cycles of reset
    a_pulse_len: assert property (@(posedge clk) disable iff (rst) // [RULE_06]
        (fire_rst && pulse_len == 2) |=> sys_reset [*3] ##1 !sys_reset)
        else $error("reset pulse length wrong");

    // The pulse drops once its length has run out
    a_pulse_end: assert property (@(posedge clk) disable iff (rst) // [RULE_06]
        (pulsing && plen_r == '0 && !fire_rst) |=> !sys_reset)
        else $error("reset pulse did not end");

    // No pulse outlives the largest programmable length
    a_pulse_bound: assert property (@(posedge clk) disable iff (rst) // [RULE_06]
        pulsing |-> !hold_r[PLEN_W])
        else $error("reset pulse too long");

    // The interrupt holds until it is cleared
    a_irq_hold: assert property (@(posedge clk) disable iff (rst) // [RULE_05]
        (irq && !irq_clear) |=> irq)
        else $error("interrupt dropped without clear");

    // A clear without a fresh timeout drops the interrupt
    a_irq_release: assert property (@(posedge clk) disable iff (rst) // [RULE_05]
        (irq_clear && !fire_irq) |=> !irq)
        else $error("interrupt not cleared");

    // Direct mode never raises the interrupt
    a_direct_no_irq: assert property (@(posedge clk) disable iff (rst) // [RULE_04]
        (!mode_irq && !irq) |=> !irq)
        else $error("interrupt raised in direct mode");

    // A stopped counter cannot start a reset pulse
    a_idle_quiet: assert property (@(posedge clk) disable iff (rst) // [RULE_03]
        (!enable && !pulsing) |=> !sys_reset)
        else $error("reset while stopped");

    // A stopped counter sits at the full span on the top range
    a_hold_full: assert property (@(posedge clk) disable iff (rst) // [RULE_01]
        (!enable && range_sel == 4'hF) |=> cnt_r == 32'hFFFFFFFF)
        else $error("counter not at full span");

    // The counter reloads itself after a timeout
    a_timeout_reload: assert property (@(posedge clk) disable iff (rst) // [RULE_08]
        (timeout && range_sel == 4'h0) |=> cnt_r == 32'((64'h1 << RANGE_BASE) - 64'h1))
        else $error("no reload after timeout");

    // Main scenarios
    c_direct: cover property (@(posedge clk) disable iff (rst) fire_rst && !mode_irq);
    c_irq: cover property (@(posedge clk) disable iff (rst) fire_irq);
    c_second: cover property (@(posedge clk) disable iff (rst) fire_rst && mode_irq);
    c_serviced: cover property (@(posedge clk) disable iff (rst) irq ##1 irq_clear ##1 !irq);
    c_retrigger: cover property (@(posedge clk) disable iff (rst) fire_rst && pulsing);
endmodule

/* File: tb/tsv_service_model.sv */
// Service model: handler that clears the interrupt after a set wait.
// Assumes irq is registered on clk; the bench sets the wait.
`timescale 1ns/1ps
module tsv_service_model
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       irq,
    input  wire logic [7:0] delay,
    output logic            irq_clear
);
    logic [7:0] wait_r;
    // One-cycle clear once the wait runs out; a long wait models a slow handler
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            wait_r    <= 8'h00;
            irq_clear <= 1'b0;
        end
        else
        begin
            wait_r    <= (irq && !irq_clear) ? wait_r + 8'h01 : 8'h00;
            irq_clear <= irq && !irq_clear && wait_r == delay;
        end
endmodule

/* File: tb/test_apb_watchdog_timer.sv */
// Bench: drives the supervisor, queues expected results, checks them in a monitor.
// Assumes one 40 MHz clock; the service model answers the interrupt.
`timescale 1ns/1ps
module test_apb_watchdog_timer;
    logic        clk, rst, enable, mode_irq, restart, irq_clear, irq, sys_reset;
    logic        irq_q, sys_q, svc_q;
    logic [3:0]  range_sel;
    logic [7:0]  pulse_len, svc_delay;
    logic [31:0] count, width;
    logic [33:0] note[$];
    int          err_count, check_count, n, seed;
    // Short ranges keep every timeout within a few hundred cycles
    localparam int unsigned TB_BASE = 4;
    tsv_timeout_supervisor #(.RANGE_BASE(TB_BASE))
        dut (.clk(clk), .rst(rst), .enable(enable), .mode_irq(mode_irq),
        .range_sel(range_sel), .pulse_len(pulse_len), .restart(restart),
        .irq_clear(irq_clear), .irq(irq), .sys_reset(sys_reset), .count(count));
    tsv_service_model svc (.clk(clk), .rst(rst), .irq(irq), .delay(svc_delay),
        .irq_clear(irq_clear));
    always #12.5 clk = ~clk;
    // Expected preset: powers of two less one, top range the full span
    function automatic logic [31:0] preset_of(input logic [3:0] k);
        preset_of = (k == 4'hF) ? 32'hFFFFFFFF : 32'((64'h1 << (TB_BASE + k)) - 64'h1);
    endfunction
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        if (err_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Bounded wait for the monitor to use up every note; a hang counts as a miss
    task automatic drain;
        for (n = 0; n < 2000 && note.size() != 0; n++)
            @(posedge clk);
        if (note.size() != 0)
        begin
            err_count++;
            stop_test;
        end
    endtask
    // Restart with range k; the counter must reload to that range's preset
    task automatic serve(input logic [3:0] k);
        @(posedge clk);
        range_sel <= k;
        restart   <= 1'b1;
        note.push_back({2'b00, preset_of(k)});
        @(posedge clk);
        restart <= 1'b0;
    endtask
    // Monitor: sampled mid-cycle so the edge's updates have landed
    always @(negedge clk)
    begin
        if (note.size() != 0 && (svc_q || (irq && !irq_q) || (sys_reset && !sys_q)))
            check({irq, sys_reset, count}, note.pop_front());
        if (note.size() != 0 && !sys_reset && sys_q)
            check({2'b11, width}, note.pop_front());
        width = sys_reset ? width + 32'h1 : 32'h0;
        irq_q = irq;
        sys_q = sys_reset;
        svc_q = restart | irq_clear;
    end
    initial
    begin
        seed = 32'hCAB5F238;
        {clk, rst, enable, mode_irq, restart} = 5'b01000;
        {range_sel, pulse_len, svc_delay} = 20'h00000;
        err_count = 0;
        check_count = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        // Every range, reloaded back to back while stopped
        for (int k = 0; k < 16; k++)
            serve(k[3:0]);
        // Direct mode, range 5 outlasts any random pulse length
        {svc_delay, pulse_len} <= 16'($random(seed));
        enable <= 1'b1;
        serve(4'h5);
        note.push_back({2'b01, preset_of(4'h5)});
        note.push_back({2'b11, 32'(pulse_len) + 32'h1});
        drain;
        // Interrupt first; the handler clears it after a random wait
        mode_irq <= 1'b1;
        serve(4'h5);
        note.push_back({2'b10, preset_of(4'h5)});
        note.push_back({2'b00, preset_of(4'h5)});
        drain;
        // Slow handler: the second timeout resets with the interrupt still set
        {svc_delay, pulse_len} <= 16'hFF02;
        serve(4'h0);
        note.push_back({2'b10, preset_of(4'h0)});
        note.push_back({2'b11, preset_of(4'h0)});
        note.push_back({2'b11, 32'h00000003});
        drain;
        stop_test;
    end
endmodule
